// >>> trap_ctl_pkg.sv
// Package with register layout and constants for the trap control register
package trap_ctl_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] TRAP_CTL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] PRIO_OFFSET = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int NEST_BIT = 15;
    localparam int OVA_BIT = 14;
    localparam int OVB_BIT = 13;
    localparam int COVA_BIT = 12;
    localparam int COVB_BIT = 11;
    localparam int OVA_TE_BIT = 10;
    localparam int OVB_TE_BIT = 9;
    localparam int COV_TE_BIT = 8;
    localparam int SHIFT_BIT = 7;
    localparam int DIV0_BIT = 6;
    localparam int DMA_BIT = 5;
    localparam int MATH_BIT = 4;
    localparam int ADDR_F_BIT = 3;
    localparam int STACK_BIT = 2;
    localparam int OSC_BIT = 1;

    // Sticky cause flags, and writable control bits
    localparam logic [REG_W-1:0] FLAG_MASK = 16'h78FE;
    localparam logic [REG_W-1:0] CTRL_MASK = 16'h8700;
    localparam logic [REG_W-1:0] TRAP_CTL_RESET = 16'h0000;
    localparam logic [REG_W-1:0] IRQ_MASK_RESET = 16'h0000;
    localparam logic [2:0] PRIO_RESET = 3'h0;
    localparam int PRIO_W = 3;

    // ------------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_type;

endpackage

// >>> trap_status_control_reg.sv
// Trap cause and nesting control register with Wishbone slave
`timescale 1ns/1ps

// Function
// - Bit 15 set to one forbids interrupt nesting, zero permits it.
// - Bit 14 latches a trap caused by accumulator A overflow.
// - Bit 13 latches a trap caused by accumulator B overflow.
// - Bit 12 latches a trap from catastrophic overflow of accumulator A.
// - Bit 11 latches a trap from catastrophic overflow of accumulator B.
// - Bit 10 enables the accumulator A overflow trap.
// - Bit 9 enables the accumulator B overflow trap.
// - Bit 8 enables the catastrophic overflow trap for both accumulators.
// - Bit 7 latches a math trap caused by an invalid accumulator shift.
// - Bit 6 latches a math trap caused by a division by zero.
// - Bit 5 latches a DMA controller trap.
// - Bit 4 latches a math trap from an invalid shift or a division by zero.
// - Bit 0 always reads zero and ignores writes.
// - Bits 3, 2 and 1 latch address, stack and oscillator fault traps.
// - While nesting is inhibited the priority level bits are read-only.
module trap_status_control_reg
    import trap_ctl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [trap_ctl_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [trap_ctl_pkg::DATA_W-1:0] wb_dat_i,
    output logic [trap_ctl_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Core trap events, one-cycle pulses
    input wire logic acc_a_overflow,
    input wire logic acc_b_overflow,
    input wire logic acc_a_catastrophic,
    input wire logic acc_b_catastrophic,
    input wire logic bad_shift,
    input wire logic divide_by_zero,
    input wire logic dma_controller_trap,
    input wire logic address_fault,
    input wire logic stack_fault,
    input wire logic oscillator_fault,
    // Trap requests and control to the core
    output logic acc_a_overflow_trap,
    output logic acc_b_overflow_trap,
    output logic catastrophic_trap,
    output logic nesting_inhibit,
    output logic [trap_ctl_pkg::PRIO_W-1:0] cpu_priority_level_bits,
    // Interrupt
    output logic irq
);
    import trap_ctl_pkg::*;

    // One clock for every check; all of them quiet while reset is low
    default clocking check_clock @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-lane merge of a 16-bit register with write data
    function automatic logic [REG_W-1:0] lane_merge(
        input logic [REG_W-1:0] old_v,
        input logic [DATA_W-1:0] wdat,
        input logic [3:0] sel
    );
        logic [REG_W-1:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wdat[15:8];
        end
        return r;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    bus_state_type bus_state_reg, bus_state_next;
    logic [REG_W-1:0] ctl_reg, ctl_next;
    logic [REG_W-1:0] mask_reg, mask_next;
    logic [PRIO_W-1:0] prio_reg, prio_next;
    logic [DATA_W-1:0] rdat_reg, rdat_next;
    logic [REG_W-1:0] events;
    logic wr_stb;

    // Events in register bit order
    always_comb begin
        events = '0;
        events[OVA_BIT] = acc_a_overflow;
        events[OVB_BIT] = acc_b_overflow;
        events[COVA_BIT] = acc_a_catastrophic;
        events[COVB_BIT] = acc_b_catastrophic;
        events[SHIFT_BIT] = bad_shift;
        events[DIV0_BIT] = divide_by_zero;
        events[DMA_BIT] = dma_controller_trap;
        events[MATH_BIT] = bad_shift | divide_by_zero;
        events[ADDR_F_BIT] = address_fault;
        events[STACK_BIT] = stack_fault;
        events[OSC_BIT] = oscillator_fault;
    end

    // ------------------------------------------------------------------
    // Bus slave: one wait cycle, ack for exactly one cycle
    // ------------------------------------------------------------------
    assign wr_stb = (bus_state_reg == BUS_IDLE) && wb_cyc_i && wb_stb_i
        && wb_we_i;

    always_comb begin
        bus_state_next = bus_state_reg;
        rdat_next = rdat_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_state_next = BUS_ACK;
                    rdat_next = '0;
                    if (hit(wb_adr_i, TRAP_CTL_OFFSET)) begin
                        rdat_next[REG_W-1:0] = ctl_reg;
                    end else if (hit(wb_adr_i, IRQ_MASK_OFFSET)) begin
                        rdat_next[REG_W-1:0] = mask_reg;
                    end else if (hit(wb_adr_i, PRIO_OFFSET)) begin
                        rdat_next[PRIO_W-1:0] = prio_reg;
                    end
                end
            end
            BUS_ACK: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_comb begin
        logic [REG_W-1:0] wv;
        wv = lane_merge(ctl_reg, wb_dat_i, wb_sel_i);
        ctl_next = ctl_reg;
        mask_next = mask_reg;
        prio_next = prio_reg;
        if (wr_stb && hit(wb_adr_i, TRAP_CTL_OFFSET)) begin
            // Control bits take the written value
            // Flags only clear on a written zero
            ctl_next = (wv & CTRL_MASK) | (ctl_reg & wv & FLAG_MASK);
        end
        if (wr_stb && hit(wb_adr_i, IRQ_MASK_OFFSET)) begin
            mask_next = lane_merge(mask_reg, wb_dat_i, wb_sel_i) & FLAG_MASK;
        end
        // Priority frozen while nesting is inhibited
        if (wr_stb && hit(wb_adr_i, PRIO_OFFSET) && wb_sel_i[0]
            && !ctl_reg[NEST_BIT]) begin
            prio_next = wb_dat_i[PRIO_W-1:0];
        end
        // Set wins over a same-cycle clear
        ctl_next = ctl_next | (events & FLAG_MASK);
        ctl_next[0] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_state_reg <= BUS_IDLE;
            rdat_reg <= '0;
            ctl_reg <= TRAP_CTL_RESET;
            mask_reg <= IRQ_MASK_RESET;
            prio_reg <= PRIO_RESET;
        end else begin
            bus_state_reg <= bus_state_next;
            rdat_reg <= rdat_next;
            ctl_reg <= ctl_next;
            mask_reg <= mask_next;
            prio_reg <= prio_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o = (bus_state_reg == BUS_ACK);
    assign wb_dat_o = rdat_reg;
    assign nesting_inhibit = ctl_reg[NEST_BIT];
    assign cpu_priority_level_bits = prio_reg;
    // Gated trap requests; combinational so the trap is not late
    assign acc_a_overflow_trap = acc_a_overflow & ctl_reg[OVA_TE_BIT];
    assign acc_b_overflow_trap = acc_b_overflow & ctl_reg[OVB_TE_BIT];
    assign catastrophic_trap = (acc_a_catastrophic | acc_b_catastrophic)
        & ctl_reg[COV_TE_BIT];
    assign irq = |(ctl_reg & mask_reg & FLAG_MASK);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_ova_event;
        acc_a_overflow;
    endsequence

    // Writes that reach the control and the priority registers
    sequence s_ctl_write;
        wr_stb && (wb_adr_i == TRAP_CTL_OFFSET);
    endsequence

    sequence s_prio_write;
        wr_stb && (wb_adr_i == PRIO_OFFSET) && wb_sel_i[0];
    endsequence

    // Each event sets its own flag by the next cycle
    a_ova_flag_set: assert property (
        s_ova_event |=> ctl_reg[OVA_BIT])
        else $error("acc A overflow flag not set");
    a_ovb_flag_set: assert property (
        acc_b_overflow |=> ctl_reg[OVB_BIT])
        else $error("acc B overflow flag not set");
    a_cova_flag_set: assert property (
        acc_a_catastrophic |=> ctl_reg[COVA_BIT])
        else $error("acc A catastrophic flag not set");
    a_covb_flag_set: assert property (
        acc_b_catastrophic |=> ctl_reg[COVB_BIT])
        else $error("acc B catastrophic flag not set");
    a_math_flag_set: assert property (
        (bad_shift || divide_by_zero) |=> ctl_reg[MATH_BIT])
        else $error("math fault flag not set");
    a_shift_flag_set: assert property (
        bad_shift |=> ctl_reg[SHIFT_BIT])
        else $error("shift flag not set");
    a_div_flag_set: assert property (
        divide_by_zero |=> ctl_reg[DIV0_BIT])
        else $error("divide flag not set");
    a_dma_flag_set: assert property (
        dma_controller_trap |=> ctl_reg[DMA_BIT])
        else $error("dma controller flag not set");
    a_addr_flag_set: assert property (
        address_fault |=> ctl_reg[ADDR_F_BIT])
        else $error("address fault flag not set");
    a_stack_flag_set: assert property (
        stack_fault |=> ctl_reg[STACK_BIT])
        else $error("stack fault flag not set");
    a_osc_flag_set: assert property (
        oscillator_fault |=> ctl_reg[OSC_BIT])
        else $error("oscillator fault flag not set");
    a_bit0_zero: assert property (
        !ctl_reg[0])
        else $error("bit 0 reads one");

    // Flags fall only where software writes the register
    a_flag_sticky: assert property (
        (ctl_reg[DIV0_BIT] && !wr_stb) |=> ctl_reg[DIV0_BIT])
        else $error("flag cleared without a write");
    a_flags_sticky_all: assert property (
        !(wr_stb && (wb_adr_i == TRAP_CTL_OFFSET)) |=>
        (($past(ctl_reg) & ~ctl_reg & FLAG_MASK) == '0))
        else $error("a flag fell without a write");

    // Control bits
    a_prio_frozen: assert property (
        nesting_inhibit |=> $stable(prio_reg))
        else $error("priority changed while nesting inhibited");
    a_prio_takes: assert property (
        (s_prio_write ##0 !nesting_inhibit) |=>
        (prio_reg == $past(wb_dat_i[PRIO_W-1:0])))
        else $error("priority write lost while nesting allowed");
    a_nest_follows: assert property (
        (s_ctl_write ##0 wb_sel_i[1]) |=>
        (nesting_inhibit == $past(wb_dat_i[NEST_BIT])))
        else $error("nesting inhibit did not take the written value");

    // Trap requests are gated both ways by the enable bits
    a_ova_trap_gate: assert property (
        (acc_a_overflow && !ctl_reg[OVA_TE_BIT]) |-> !acc_a_overflow_trap)
        else $error("acc A trap not suppressed");
    a_ova_trap_raise: assert property (
        (acc_a_overflow && ctl_reg[OVA_TE_BIT]) |-> acc_a_overflow_trap)
        else $error("acc A trap not raised");
    a_ovb_trap_gate: assert property (
        acc_b_overflow_trap |-> ctl_reg[OVB_TE_BIT])
        else $error("acc B trap while disabled");
    a_ovb_trap_raise: assert property (
        (acc_b_overflow && ctl_reg[OVB_TE_BIT]) |-> acc_b_overflow_trap)
        else $error("acc B trap not raised");
    a_cov_trap_gate: assert property (
        ((acc_a_catastrophic || acc_b_catastrophic) && ctl_reg[COV_TE_BIT])
        |-> catastrophic_trap)
        else $error("catastrophic trap not raised");
    a_cov_trap_quiet: assert property (
        catastrophic_trap |-> ctl_reg[COV_TE_BIT])
        else $error("catastrophic trap while disabled");

    // Bus answer and interrupt level
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    a_irq_raise: assert property (
        (|(events & mask_reg)) ##1 (mask_reg == $past(mask_reg)) |-> irq)
        else $error("masked-in event did not raise the interrupt");
    a_mask_layout: assert property (
        (mask_reg & ~FLAG_MASK) == '0)
        else $error("mask holds a bit outside the flag field");

endmodule

// >>> trap_core_model.sv
// Partner model: core trap logic raising one-cycle trap event pulses
`timescale 1ns/1ps
module trap_core_model (
    // Clock
    input wire logic clk,
    // Request from the bench
    input wire logic fire,
    input wire logic [3:0] idx,
    // Trap events
    output logic [9:0] ev
);
    // Registered, so a one-cycle request gives a one-cycle pulse
    initial ev = 10'h000;
    always @(posedge clk) begin
        ev <= fire ? 10'(1 << idx) : 10'h000;
    end
endmodule

// >>> testbench.sv
// Self-checking testbench for the trap cause and nesting register
`timescale 1ns/1ps
module testbench;
    import trap_ctl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic fire = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [ADDR_W-1:0] adr = '0;
    logic [DATA_W-1:0] wdat = '0;
    logic [DATA_W-1:0] rdat;
    logic [DATA_W-1:0] rd;
    logic ack, a_trap, b_trap, c_trap, nest, irq;
    logic [9:0] ev;
    logic [PRIO_W-1:0] prio;
    int n_errors = 0;
    int checks = 0;
    logic [31:0] seed = 32'hd572;
    logic [15:0] mctl = 16'h0000;
    logic [15:0] mmask = 16'h0000;
    logic [2:0] mprio = 3'h0;
    logic [15:0] v;
    logic [3:0] sel = 4'h0;
    logic [3:0] lanes = 4'h3;
    int pos[10] = '{14, 13, 12, 11, 7, 6, 5, 3, 2, 1};

    always #4 clk = ~clk;

    trap_core_model core (.clk(clk), .fire(fire), .idx(idx), .ev(ev));

    trap_status_control_reg DUT (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .acc_a_overflow(ev[0]),
        .acc_b_overflow(ev[1]), .acc_a_catastrophic(ev[2]),
        .acc_b_catastrophic(ev[3]), .bad_shift(ev[4]),
        .divide_by_zero(ev[5]), .dma_controller_trap(ev[6]),
        .address_fault(ev[7]), .stack_fault(ev[8]),
        .oscillator_fault(ev[9]), .acc_a_overflow_trap(a_trap),
        .acc_b_overflow_trap(b_trap), .catastrophic_trap(c_trap),
        .nesting_inhibit(nest), .cpu_priority_level_bits(prio), .irq(irq));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // One classic cycle; waits for ack without assuming its latency
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= lanes;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr_ctl(input logic [15:0] w);
        logic [15:0] m;
        m = {lanes[1] ? w[15:8] : mctl[15:8], lanes[0] ? w[7:0] : mctl[7:0]};
        bus(1'b1, TRAP_CTL_OFFSET, w);
        mctl = (mctl & FLAG_MASK & m) | (m & CTRL_MASK);
        bus(1'b0, TRAP_CTL_OFFSET, 16'h0000);
        chk("ctl", rd, {16'h0000, mctl});
        chk("nest", nest, mctl[NEST_BIT]);
        chk("irq", irq, |(mctl & mmask & FLAG_MASK));
    endtask

    task automatic fire_ev(input int i);
        logic [2:0] e;
        e = {i == 0 && mctl[10], i == 1 && mctl[9], i > 1 && i < 4 && mctl[8]};
        @(posedge clk);
        fire <= 1'b1;
        idx <= 4'(i);
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        chk("trap_req", {a_trap, b_trap, c_trap}, e);
        mctl[pos[i]] = 1'b1;
        if (i == 4 || i == 5) mctl[MATH_BIT] = 1'b1;
        @(posedge clk);
        chk("irq", irq, |(mctl & mmask & FLAG_MASK));
        bus(1'b0, TRAP_CTL_OFFSET, 16'h0000);
        chk("flags", rd, {16'h0000, mctl});
        chk("flag_map", rd[pos[i]], 1'b1);
    endtask

    task automatic close_out();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        #(8 * 20000);
        n_errors++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Unmapped offset 0xC is in this sweep too
        for (int a = 0; a < 16; a += 4) begin
            bus(1'b0, 4'(a), 16'h0000);
            chk("reset_rd", rd, 32'h0000_0000);
        end
        v = 16'(rnd());
        bus(1'b1, IRQ_MASK_OFFSET, v);
        mmask = v & FLAG_MASK;
        for (int i = 0; i < 10; i++) begin
            v = 16'(rnd()) | FLAG_MASK;
            v[NEST_BIT] = i[0];
            wr_ctl(v);
            v = 16'(rnd());
            bus(1'b1, PRIO_OFFSET, v);
            if (!mctl[NEST_BIT]) mprio = v[2:0];
            chk("prio", prio, mprio);
            fire_ev(i);
        end
        wr_ctl(16'(rnd()));
        bus(1'b1, IRQ_MASK_OFFSET, 16'hFFFF);
        mmask = FLAG_MASK;
        bus(1'b0, IRQ_MASK_OFFSET, 16'h0000);
        chk("mask", rd, {16'h0000, mmask});
        // Single-lane writes reach only their own byte
        lanes = 4'h2;
        wr_ctl(16'h00FF);
        lanes = 4'h1;
        wr_ctl(16'h0000);
        lanes = 4'h3;
        wr_ctl(16'hFFFF);
        wr_ctl(16'h0000);
        close_out();
    end
endmodule
